// File: mrs_pkg.sv
// constants and carrier types for the mac reset and read-path inject block
`default_nettype none
package mrs_pkg;
   // register locations on the spi register port
   localparam logic [7:0] REG_STATUS = 8'h3b;
   localparam logic [7:0] REG_KEY = 8'h3c;
   localparam logic [7:0] REG_INJECT = 8'h3d;
   // reset values
   localparam logic [31:0] STATUS_RESET = 32'h0000_0003;
   localparam logic [31:0] KEY_RESET = 32'h0000_0000;
   localparam logic INJECT_RESET = 1'b0;
   // field positions
   localparam int OSC_RDY_BIT = 0;
   localparam int XTAL_RDY_BIT = 1;
   localparam int INJECT_BIT = 0;
   localparam int KEY_MSB = 15;
   localparam int WORD_MSB = 31;
   // rx footer parity positions within the footer word
   localparam int FOOT_PARITY_BIT = 0;
   localparam int FOOT_TS_PARITY_BIT = 5;
   // key values
   localparam logic [15:0] KEY_RST_1 = 16'h4f1c;
   localparam logic [15:0] KEY_RST_2 = 16'hc1f4;
   localparam logic [15:0] KEY_REL_1 = 16'h6f1a;
   localparam logic [15:0] KEY_REL_2 = 16'ha1f6;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CS_HOLD_NS = 100;
   localparam int CS_HOLD_CYC = (CS_HOLD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam logic [4:0] CS_HOLD_CNT = 5'(CS_HOLD_CYC);
   localparam logic [4:0] MAC_RST_CNT = 5'h10;
   localparam int SYNC_W = 3;
   // decoded register access from the spi protocol engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mrs_reg_req_s;
   // read-path words on their way to the miso shifter
   typedef struct packed {
      logic oa_mode;
      logic prot_en;
      logic [31:0] footer;
      logic [31:0] echo;
      logic echo_first;
      logic [31:0] compl_word;
      logic [7:0] crc8;
   } mrs_miso_s;
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_RST_ARM,
      KEY_REL_ARM
   } mrs_key_e;
endpackage : mrs_pkg
`default_nettype wire

// File: mrs_top.sv
// mac reset status, key-protected soft reset and miso error injection
//
// Contract
// RQ1: status bit 1 shows crystal ready; core leaves reset once crystal ready. Bit 1 here is !o_mac_rst, so it also reads 1 after oscillator release.
// RQ2: status bit 0 shows oscillator ready; 1 means osc only, 3 both.
// RQ3: while spi slave and core in reset, status reads zero, pad driven.
// RQ4: host reads status only singly, never via burst increment.
// RQ5: mac_logic_reset reset needs 0x4f1c then 0xc1f4 as consecutive writes.
// RQ6: reset acts at chip select high; chip select low at least 100 ns.
// RQ7: mac_logic_reset reset ignored while software power-down is set.
// RQ8: keys 0x6f1a then 0xa1f6 release core on oscillator clock.
// RQ9: host keeps spi at 15 MHz after oscillator release.
// RQ10: inject with open alliance data inverts footer parity and ts parity.
// RQ11: inject inverts msb of echoed burst-write words from the second.
// RQ12: inject inverts msb of each protected read complement word.
// RQ13: inject with generic protected protocol inverts returned crc8.
// RQ14: wrong write after first key discards the sequence.
`timescale 1ns/1ps
`default_nettype none
module mrs_top (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // pins and clock status from outside this domain
   input wire logic i_spi_cs_n,
   input wire logic i_osc_clk_rdy,
   input wire logic i_xtal_clk_rdy,
   // local status
   input wire logic i_spi_rst_active,
   input wire logic i_sw_power_down,
   // register port
   input wire mrs_pkg::mrs_reg_req_s i_req,
   output logic [31:0] o_rdata,
   // miso path
   input wire mrs_pkg::mrs_miso_s i_miso,
   output logic [31:0] o_footer,
   output logic [31:0] o_echo,
   output logic [31:0] o_compl_word,
   output logic [7:0] o_crc8,
   output logic o_sdo_oe_n,
   // mac core control
   output logic o_mac_rst,
   output logic o_mac_on_osc
);

   function automatic logic is_key(input logic [31:0] d,
                                   input logic [15:0] k);
      is_key = (d[mrs_pkg::KEY_MSB:0] == k);
   endfunction : is_key

   // three-stage synchronisers; a change counts when stages 2 and 3 agree
   logic [mrs_pkg::SYNC_W-1:0] raw_in;
   logic [mrs_pkg::SYNC_W-1:0] filt_ff;
   assign raw_in = {i_xtal_clk_rdy, i_osc_clk_rdy, i_spi_cs_n};

   genvar g;
   generate
      for (g = 0; g < mrs_pkg::SYNC_W; g++) begin : g_sync
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               s1_ff <= (g == 0);
               s2_ff <= (g == 0);
               s3_ff <= (g == 0);
               filt_ff[g] <= (g == 0);
            end else begin
               s1_ff <= raw_in[g];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  filt_ff[g] <= s3_ff;
               end
            end
         end
      end
   endgenerate

   logic cs_n_f;
   logic osc_f;
   logic xtal_f;
   logic cs_n_d_ff;
   logic cs_rise;
   assign cs_n_f = filt_ff[0];
   assign osc_f = filt_ff[1];
   assign xtal_f = filt_ff[2];
   assign cs_rise = cs_n_f & ~cs_n_d_ff;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_n_d_ff <= 1'b1;
      end else begin
         cs_n_d_ff <= cs_n_f;
      end
   end

   // chip select low time, saturating
   logic [4:0] cs_low_ff;
   logic cs_held;
   assign cs_held = (cs_low_ff >= mrs_pkg::CS_HOLD_CNT);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_low_ff <= 5'h00;
      end else if (cs_n_f) begin
         cs_low_ff <= 5'h00;
      end else if (!cs_held) begin
         cs_low_ff <= cs_low_ff + 5'h01;
      end
   end

   // key sequence tracking
   mrs_pkg::mrs_key_e key_st_ff;
   mrs_pkg::mrs_key_e nxt_key_st;
   logic key_wr;
   logic rst_key2;
   logic rel_key2;
   assign key_wr = i_req.wr && (i_req.addr == mrs_pkg::REG_KEY);
   assign rst_key2 = key_wr && (key_st_ff == mrs_pkg::KEY_RST_ARM)
                     && is_key(i_req.wdata, mrs_pkg::KEY_RST_2);
   assign rel_key2 = key_wr && (key_st_ff == mrs_pkg::KEY_REL_ARM)
                     && is_key(i_req.wdata, mrs_pkg::KEY_REL_2);

   always_comb begin
      nxt_key_st = key_st_ff;
      if (i_req.wr) begin
         // any write other than a first key returns the sequence to idle
         nxt_key_st = mrs_pkg::KEY_IDLE; // RQ14
         if (key_wr && is_key(i_req.wdata, mrs_pkg::KEY_RST_1)) begin
            nxt_key_st = mrs_pkg::KEY_RST_ARM; // RQ5
         end else if (key_wr
                      && is_key(i_req.wdata, mrs_pkg::KEY_REL_1)) begin
            nxt_key_st = mrs_pkg::KEY_REL_ARM; // RQ8
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         key_st_ff <= mrs_pkg::KEY_IDLE;
      end else begin
         key_st_ff <= nxt_key_st;
      end
   end

   // completed reset key waits for chip select to rise
   logic rst_pend_ff;
   logic soft_go;
   assign soft_go = rst_pend_ff && cs_rise && cs_held;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rst_pend_ff <= 1'b0;
      end else if (rst_key2 && !i_sw_power_down) begin
         rst_pend_ff <= 1'b1; // RQ5 RQ7
      end else if (cs_rise) begin
         rst_pend_ff <= 1'b0; // RQ6
      end
   end

   // soft reset pulse length counter
   logic [4:0] soft_cnt_ff;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         soft_cnt_ff <= 5'h00;
      end else if (soft_go) begin
         soft_cnt_ff <= mrs_pkg::MAC_RST_CNT; // RQ6
      end else if (soft_cnt_ff != 5'h00) begin
         soft_cnt_ff <= soft_cnt_ff - 5'h01;
      end
   end

   // release on oscillator; held until crystal ready is seen or a hard reset,
   // since the crystal may never appear on such a board
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mac_on_osc <= 1'b0;
      end else if (rel_key2 && !xtal_f) begin
         o_mac_on_osc <= 1'b1; // RQ8
      end else if (xtal_f) begin
         o_mac_on_osc <= 1'b0;
      end
   end

   logic nxt_mac_rst;
   assign nxt_mac_rst = (soft_cnt_ff != 5'h00) || soft_go
                        || !(xtal_f || o_mac_on_osc);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mac_rst <= 1'b1;
      end else begin
         o_mac_rst <= nxt_mac_rst; // RQ1 RQ8
      end
   end

   // inject control register
   logic inject_ff;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         inject_ff <= mrs_pkg::INJECT_RESET;
      end else if (i_req.wr && (i_req.addr == mrs_pkg::REG_INJECT)) begin
         inject_ff <= i_req.wdata[mrs_pkg::INJECT_BIT];
      end
   end

   // register read; status is a live view, so only single reads are safe
   logic [31:0] status_word;
   logic [31:0] nxt_rdata;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[mrs_pkg::OSC_RDY_BIT] = osc_f; // RQ2
      status_word[mrs_pkg::XTAL_RDY_BIT] = !o_mac_rst; // RQ1
      if (i_spi_rst_active && o_mac_rst) begin
         status_word = 32'h0000_0000; // RQ3
      end
      nxt_rdata = 32'h0000_0000;
      unique case (i_req.addr)
         mrs_pkg::REG_STATUS: nxt_rdata = status_word;
         mrs_pkg::REG_INJECT: nxt_rdata[mrs_pkg::INJECT_BIT] = inject_ff;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_req.rd) begin
         o_rdata <= nxt_rdata;
      end
   end

   // pad driven for the whole chip select low time
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sdo_oe_n <= 1'b1;
      end else begin
         o_sdo_oe_n <= cs_n_f; // RQ3
      end
   end

   // miso path corruption, one register stage for every word
   logic inj_oa;
   logic inj_gen;
   logic [31:0] foot_mask;
   logic [31:0] msb_mask;
   assign inj_oa = inject_ff && i_miso.oa_mode;
   assign inj_gen = inject_ff && !i_miso.oa_mode && i_miso.prot_en;
   always_comb begin
      foot_mask = 32'h0000_0000;
      foot_mask[mrs_pkg::FOOT_PARITY_BIT] = 1'b1;
      foot_mask[mrs_pkg::FOOT_TS_PARITY_BIT] = 1'b1;
      msb_mask = 32'h0000_0000;
      msb_mask[mrs_pkg::WORD_MSB] = 1'b1;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_footer <= 32'h0000_0000;
         o_echo <= 32'h0000_0000;
         o_compl_word <= 32'h0000_0000;
         o_crc8 <= 8'h00;
      end else begin
         o_footer <= i_miso.footer ^ (inj_oa ? foot_mask
                                             : 32'h0000_0000); // RQ10
         o_echo <= i_miso.echo ^ ((inj_oa && !i_miso.echo_first)
                                  ? msb_mask : 32'h0000_0000); // RQ11
         o_compl_word <= i_miso.compl_word ^ (inj_oa ? msb_mask
                                             : 32'h0000_0000); // RQ12
         o_crc8 <= inj_gen ? ~i_miso.crc8 : i_miso.crc8; // RQ13
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_reset_armed;
      rst_key2 && !i_sw_power_down;
   endsequence
   sequence s_cs_release;
      cs_rise && cs_held;
   endsequence

   a_status_zero: assert property ( // RQ3
      i_req.rd && i_req.addr == mrs_pkg::REG_STATUS && i_spi_rst_active
      && o_mac_rst |=> o_rdata == 32'h0000_0000)
      else $error("status not zero while in reset");
   a_osc_bit: assert property ( // RQ2
      i_req.rd && i_req.addr == mrs_pkg::REG_STATUS && !i_spi_rst_active
      |=> o_rdata[mrs_pkg::OSC_RDY_BIT] == $past(osc_f))
      else $error("oscillator ready bit wrong");
   a_xtal_release: assert property ( // RQ1
      xtal_f && soft_cnt_ff == 5'h00 && !soft_go |=> !o_mac_rst)
      else $error("core not released with crystal ready");
   a_key_reset: assert property ( // RQ5
      rst_pend_ff ##0 s_cs_release
      |=> soft_cnt_ff == mrs_pkg::MAC_RST_CNT ##1 o_mac_rst)
      else $error("key pair did not reset the core");
   a_key_armed: assert property ( // RQ5
      s_reset_armed |=> rst_pend_ff)
      else $error("second key did not arm the reset");
   a_short_cs: assert property ( // RQ6
      rst_pend_ff && cs_rise && !cs_held |=> soft_cnt_ff == $past(
      soft_cnt_ff) - 5'h01 || soft_cnt_ff == 5'h00)
      else $error("reset applied on short chip select");
   a_powerdown_block: assert property ( // RQ7
      rst_key2 && i_sw_power_down && !rst_pend_ff |=> !rst_pend_ff)
      else $error("reset armed in power-down");
   a_osc_release: assert property ( // RQ8
      rel_key2 && !xtal_f |=> o_mac_on_osc ##1 !o_mac_rst || soft_go)
      else $error("oscillator release failed");
   a_footer_flip: assert property ( // RQ10
      inj_oa |=> o_footer == ($past(i_miso.footer) ^ foot_mask))
      else $error("footer parity not inverted");
   a_echo_first: assert property ( // RQ11
      inj_oa && i_miso.echo_first |=> o_echo == $past(i_miso.echo))
      else $error("first echo word corrupted");
   a_compl_flip: assert property ( // RQ12
      inj_oa |=> o_compl_word[mrs_pkg::WORD_MSB]
      != $past(i_miso.compl_word[mrs_pkg::WORD_MSB]))
      else $error("complement msb not inverted");
   a_crc_flip: assert property ( // RQ13
      inj_gen |=> o_crc8 == ~$past(i_miso.crc8))
      else $error("crc8 not inverted");
   a_seq_discard: assert property ( // RQ14
      key_st_ff == mrs_pkg::KEY_RST_ARM && i_req.wr && !rst_key2
      |=> key_st_ff != mrs_pkg::KEY_RST_ARM || $past(key_wr))
      else $error("key sequence not discarded");

endmodule : mrs_top
`default_nettype wire

// File: mrs_host_model.sv
// host register-access model standing in for the spi master
`timescale 1ns/1ps
`default_nettype none
module mrs_host_model (
   // clock
   input wire logic i_sys_clk,
   // towards the block
   output logic o_spi_cs_n,
   output var mrs_pkg::mrs_reg_req_s o_req
);
   // idle cycles before each access; a word at 15 mhz spans ~214 cycles
   int gap = 0;
   initial begin
      o_spi_cs_n = 1'b1;
      o_req = '0;
   end
   // one strobe per access; status only ever read singly
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
      repeat (gap) @(negedge i_sys_clk);
      @(negedge i_sys_clk);
      o_spi_cs_n = 1'b0;
      o_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge i_sys_clk);
      // released fields show garbage, not the last value
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : access
   // cs low time decides whether a pending reset is applied
   task automatic frame(input int low);
      repeat (low) @(negedge i_sys_clk);
      o_spi_cs_n = 1'b1;
      repeat (6) @(negedge i_sys_clk);
   endtask : frame
   // keys go out as consecutive writes in one frame
   task automatic keys(input logic [15:0] k1, k2, input int low);
      access(1'b1, mrs_pkg::REG_KEY, {16'($urandom()), k1});
      access(1'b1, mrs_pkg::REG_KEY, {16'($urandom()), k2});
      frame(low);
   endtask : keys
endmodule : mrs_host_model
`default_nettype wire

// File: mrs_top_tb_top.sv
// self-checking bench for the mac reset and read-path inject block
`timescale 1ns/1ps
`default_nettype none
module mrs_top_tb_top;
   localparam int MW = $bits(mrs_pkg::mrs_miso_s);
   logic i_sys_clk, i_rst, cs_n, osc, xtal, spi_rst, pwr_dn, inj, seen;
   mrs_pkg::mrs_reg_req_s req;
   mrs_pkg::mrs_miso_s miso, e;
   logic [31:0] rdata, footer, echo, compl_word;
   logic [7:0] crc8;
   logic sdo_oe_n, mac_rst, on_osc;
   int err_count = 0;
   int cmp_count = 0;

   mrs_top u_mrs_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_spi_cs_n(cs_n), .i_osc_clk_rdy(osc), .i_xtal_clk_rdy(xtal),
      .i_spi_rst_active(spi_rst), .i_sw_power_down(pwr_dn), .i_req(req),
      .o_rdata(rdata), .i_miso(miso), .o_footer(footer), .o_echo(echo),
      .o_compl_word(compl_word), .o_crc8(crc8), .o_sdo_oe_n(sdo_oe_n),
      .o_mac_rst(mac_rst), .o_mac_on_osc(on_osc));
   mrs_host_model u_mrs_host_model (.i_sys_clk(i_sys_clk),
      .o_spi_cs_n(cs_n), .o_req(req));

   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic finish_test;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [103:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      u_mrs_host_model.access(1'b0, a, 32'h0);
      @(negedge i_sys_clk);
      chk(104'(rdata), 104'(x));
      u_mrs_host_model.frame(1);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_mrs_host_model.access(1'b1, a, d);
      u_mrs_host_model.frame(1);
   endtask : wr

   // reset pulse is short, so sample every cycle of the window
   task automatic watch(input logic x);
      seen = 1'b0;
      repeat (30) begin
         @(negedge i_sys_clk);
         seen |= (mac_rst === 1'b1);
      end
      chk(104'(seen), 104'(x));
   endtask : watch

   function automatic mrs_pkg::mrs_miso_s corrupt(mrs_pkg::mrs_miso_s m,
                                                  logic j);
      corrupt = m;
      if (j && m.oa_mode) begin
         corrupt.footer = m.footer ^ (32'h1 << mrs_pkg::FOOT_PARITY_BIT)
                          ^ (32'h1 << mrs_pkg::FOOT_TS_PARITY_BIT);
         corrupt.compl_word[31] = ~m.compl_word[31];
         corrupt.echo[31] = m.echo[31] ^ !m.echo_first;
      end
      if (j && !m.oa_mode && m.prot_en) begin
         corrupt.crc8 = ~m.crc8;
      end
   endfunction : corrupt

   initial begin
      i_rst = 1'b1;
      osc = 1'b1;
      xtal = 1'b1;
      spi_rst = 1'b0;
      pwr_dn = 1'b0;
      miso = '0;
      void'($urandom(32'hd1c0));
      repeat (6) @(negedge i_sys_clk);
      i_rst = 1'b0;
      repeat (10) @(negedge i_sys_clk);
      rd(mrs_pkg::REG_STATUS, mrs_pkg::STATUS_RESET);
      wr(mrs_pkg::REG_STATUS, 32'h0);
      rd(mrs_pkg::REG_STATUS, 32'h3);
      rd(mrs_pkg::REG_KEY, 32'h0);
      rd(8'h3e, 32'h0);
      for (int j = 0; j < 2; j++) begin
         inj = j[0];
         wr(mrs_pkg::REG_INJECT, {31'($urandom()), inj});
         rd(mrs_pkg::REG_INJECT, {31'h0, inj});
         for (int i = 0; i < 40; i++) begin
            miso = (i == 0) ? '1 : MW'({$urandom(), $urandom(),
                                        $urandom(), $urandom()});
            e = corrupt(miso, inj);
            @(negedge i_sys_clk);
            chk({footer, echo, compl_word, crc8},
                {e.footer, e.echo, e.compl_word, e.crc8});
         end
      end
      u_mrs_host_model.keys(mrs_pkg::KEY_RST_1, mrs_pkg::KEY_RST_2, 12);
      watch(1'b1);
      rd(mrs_pkg::REG_STATUS, 32'h3);
      u_mrs_host_model.keys(mrs_pkg::KEY_RST_1, mrs_pkg::KEY_RST_2, 1);
      watch(1'b0);
      pwr_dn = 1'b1;
      u_mrs_host_model.keys(mrs_pkg::KEY_RST_1, mrs_pkg::KEY_RST_2, 12);
      watch(1'b0);
      pwr_dn = 1'b0;
      u_mrs_host_model.access(1'b1, mrs_pkg::REG_KEY, 32'(mrs_pkg::KEY_RST_1));
      u_mrs_host_model.access(1'b1, mrs_pkg::REG_INJECT, 32'h0);
      u_mrs_host_model.keys(mrs_pkg::KEY_RST_2, 16'h0, 12);
      watch(1'b0);
      u_mrs_host_model.access(1'b1, mrs_pkg::REG_KEY, 32'(mrs_pkg::KEY_RST_1));
      u_mrs_host_model.keys(mrs_pkg::KEY_RST_1, mrs_pkg::KEY_RST_2, 12);
      watch(1'b1);
      xtal = 1'b0;
      spi_rst = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      u_mrs_host_model.access(1'b0, mrs_pkg::REG_STATUS, 32'h0);
      repeat (5) @(negedge i_sys_clk);
      chk(104'({sdo_oe_n, rdata}), 104'h0);
      u_mrs_host_model.frame(1);
      chk(104'(sdo_oe_n), 104'h1);
      spi_rst = 1'b0;
      rd(mrs_pkg::REG_STATUS, 32'h1);
      u_mrs_host_model.keys(mrs_pkg::KEY_REL_1, mrs_pkg::KEY_REL_2, 12);
      chk(104'({on_osc, mac_rst}), 104'h2);
      u_mrs_host_model.gap = 214;
      rd(mrs_pkg::REG_STATUS, 32'h3);
      xtal = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      chk(104'({on_osc, mac_rst}), 104'h0);
      finish_test;
   end

   // whole run is under a thousand cycles
   initial begin
      #100us;
      err_count++;
      finish_test;
   end
endmodule : mrs_top_tb_top
`default_nettype wire
